// >>> design/lasu_params.svh
// constants for the logic and arithmetic shift unit
`ifndef LASU_PARAMS_SVH
`define LASU_PARAMS_SVH
// opcode group selectors
`define LASU_GRP_AND      4'hc
`define LASU_GRP_SHIFT    4'he
`define LASU_AND_IMMEDIATE_HI      8'h02
`define LASU_AND_IMMEDIATE_FLAGS   16'h023c
// size codes
`define LASU_SZ_BYTE      2'h0
`define LASU_SZ_WORD      2'h1
`define LASU_SZ_LONG      2'h2
`define LASU_SZ_MEM       2'h3
// effective operand modes
`define LASU_MODE_DREG    3'h0
`define LASU_MODE_AREG    3'h1
`define LASU_MODE_EXT     3'h7
`define LASU_REG_ABS_W    3'h0
`define LASU_REG_ABS_L    3'h1
`define LASU_REG_PC_D16   3'h2
`define LASU_REG_PC_IDX   3'h3
`define LASU_REG_IMM      3'h4
// flag bit positions in the flag byte
`define LASU_FL_C         0
`define LASU_FL_V         1
`define LASU_FL_Z         2
`define LASU_FL_N         3
`define LASU_FL_X         4
// shift counts
`define LASU_CNT_MOD_MASK 6'h3f
`define LASU_CNT_ZERO_IS  6'h08
`define LASU_CNT_ONE      6'h01
`endif

// >>> design/lasu_pkg.sv
// types for the logic and arithmetic shift unit
package lasu_pkg;
   typedef enum logic [2:0] {
      LASU_OP_NONE,
      LASU_OP_AND_TO_REG,
      LASU_OP_AND_TO_MEM,
      LASU_OP_AND_IMMEDIATE,
      LASU_OP_AND_IMMEDIATE_FLAGS,
      LASU_OP_SHIFT_REG,
      LASU_OP_SHIFT_MEM
   } lasu_op_t;

   typedef struct packed {
      logic [31:0] result;
      logic [4:0]  flags;
      logic        wr_reg;
      logic        wr_mem;
      logic [2:0]  wr_idx;
      logic        illegal;
      logic        done;
   } lasu_state_t;

   typedef struct packed {
      logic [31:0] value;
      logic        carry;
      logic        ovf;
   } lasu_shift_t;
endpackage

// >>> design/lasu_shifter.sv
// arithmetic shifter for byte, word and long operands
`timescale 1ns/1ps
`include "lasu_params.svh"
module lasu_shifter #(
   parameter int W = 32
) (
   // operand and control
   input  wire logic [W-1:0] operand,
   input  wire logic [1:0]   size,
   input  wire logic [5:0]   count,
   input  wire logic         left,
   // result
   output logic [W-1:0]      value,
   output logic              carry,
   output logic              ovf
);
   // walk the count one bit at a time; count is at most 63 so the loop is bounded
   always_comb begin
      logic [W-1:0] v;
      logic         msb;
      logic         sign0;
      v     = operand;
      msb   = 1'b0;
      sign0 = 1'b0;
      carry = 1'b0;
      ovf   = 1'b0;
      case (size)
         `LASU_SZ_BYTE: sign0 = operand[7];
         `LASU_SZ_WORD: sign0 = operand[15];
         default:       sign0 = operand[W-1];
      endcase
      for (int i = 0; i < 64; i++) begin
         if (6'(i) < count) begin
            case (size)
               `LASU_SZ_BYTE: msb = v[7];
               `LASU_SZ_WORD: msb = v[15];
               default:       msb = v[W-1];
            endcase
            if (left) begin
               carry = msb;
               v     = {v[W-2:0], 1'b0};
            end else begin
               carry = v[0];
               v     = v >> 1;
               case (size)
                  `LASU_SZ_BYTE: v[7]   = sign0;
                  `LASU_SZ_WORD: v[15]  = sign0;
                  default:       v[W-1] = sign0;
               endcase
            end
            case (size)
               `LASU_SZ_BYTE: ovf = ovf | (v[7] != sign0);
               `LASU_SZ_WORD: ovf = ovf | (v[15] != sign0);
               default:       ovf = ovf | (v[W-1] != sign0);
            endcase
         end
      end
      ovf   = left & ovf;
      value = v;
   end
endmodule // lasu_shifter

// >>> design/lasu_unit.sv
`timescale 1ns/1ps
`include "lasu_params.svh"
module lasu_unit #(
   parameter int W = 32
) (
   // clock, reset, enable
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic         ce,
   // instruction
   input  wire logic         issue,
   input  wire logic [15:0]  opcode,
   input  wire logic [15:0]  ext_word0,
   input  wire logic [15:0]  ext_word1,
   // operands
   input  wire logic [W-1:0] data_reg_val,
   input  wire logic [W-1:0] count_reg_val,
   input  wire logic [W-1:0] mem_operand,
   input  wire logic [4:0]   flag_byte_in,
   // results
   output logic [W-1:0]      result,
   output logic [4:0]        flag_byte,
   output logic              wr_data_reg,
   output logic              wr_mem,
   output logic [2:0]        wr_reg_idx,
   output logic              illegal,
   output logic              done
);
   // ========================================
   // field decode
   logic [3:0]          grp;
   logic [2:0]          reg_fld;
   logic [2:0]          opm;
   logic [2:0]          ea_mode;
   logic [2:0]          ea_reg;
   logic [1:0]          size;
   logic                shift_direction_bit;
   lasu_pkg::lasu_op_t  op;
   logic                legal;
   assign grp                 = opcode[15:12];
   assign reg_fld             = opcode[11:9];
   assign opm                 = opcode[8:6];
   assign ea_mode             = opcode[5:3];
   assign ea_reg              = opcode[2:0];
   assign size                = opcode[7:6];
   assign shift_direction_bit = opcode[8];

   // mode classes of the effective operand
   logic is_dreg, is_areg, is_ext_ok, is_data, is_mem_alt;
   assign is_dreg    = ea_mode == `LASU_MODE_DREG;
   assign is_areg    = ea_mode == `LASU_MODE_AREG;
   assign is_ext_ok  = ea_mode == `LASU_MODE_EXT
                       && (ea_reg == `LASU_REG_ABS_W || ea_reg == `LASU_REG_ABS_L);
   assign is_data    = (ea_mode != `LASU_MODE_AREG && ea_mode != `LASU_MODE_EXT)
                       || is_ext_ok
                       || (ea_mode == `LASU_MODE_EXT && (ea_reg == `LASU_REG_IMM
                           || ea_reg == `LASU_REG_PC_D16 || ea_reg == `LASU_REG_PC_IDX));
   assign is_mem_alt = (!is_dreg && !is_areg && ea_mode != `LASU_MODE_EXT) || is_ext_ok;

   // classify opcode and legality
   always_comb begin
      op    = lasu_pkg::LASU_OP_NONE;
      legal = 1'b0;
      if (opcode == `LASU_AND_IMMEDIATE_FLAGS) begin
         op    = lasu_pkg::LASU_OP_AND_IMMEDIATE_FLAGS;
         legal = ext_word0[15:8] == 8'h00;
      end else if (opcode[15:8] == `LASU_AND_IMMEDIATE_HI) begin
         op    = lasu_pkg::LASU_OP_AND_IMMEDIATE;
         legal = size != `LASU_SZ_MEM && (is_dreg || is_mem_alt);
      end else if (grp == `LASU_GRP_AND) begin
         if (opm[2] == 1'b0) begin
            op    = lasu_pkg::LASU_OP_AND_TO_REG;
            legal = opm[1:0] != `LASU_SZ_MEM && is_data;
         end else begin
            op    = lasu_pkg::LASU_OP_AND_TO_MEM;
            legal = opm[1:0] != `LASU_SZ_MEM && is_mem_alt;
         end
      end else if (grp == `LASU_GRP_SHIFT && opcode[4:3] == 2'h0 && size != `LASU_SZ_MEM) begin
         op    = lasu_pkg::LASU_OP_SHIFT_REG;
         legal = 1'b1;
      end else if (grp == `LASU_GRP_SHIFT && size == `LASU_SZ_MEM && reg_fld == 3'h0) begin
         op    = lasu_pkg::LASU_OP_SHIFT_MEM;
         legal = is_mem_alt;
      end
   end

   // ========================================
   // operand size and immediate
   logic [1:0]   op_size;
   logic [W-1:0] imm;
   logic [W-1:0] size_mask;
   always_comb begin
      case (op)
         lasu_pkg::LASU_OP_AND_TO_REG,
         lasu_pkg::LASU_OP_AND_TO_MEM: op_size = opm[1:0];
         lasu_pkg::LASU_OP_SHIFT_MEM:  op_size = `LASU_SZ_WORD;
         default:                      op_size = size;
      endcase
      case (op_size)
         `LASU_SZ_BYTE: imm = W'({24'h0, ext_word0[7:0]});
         `LASU_SZ_WORD: imm = W'({16'h0, ext_word0});
         default:       imm = W'({ext_word0, ext_word1});
      endcase
      case (op_size)
         `LASU_SZ_BYTE: size_mask = W'(32'h0000_00ff);
         `LASU_SZ_WORD: size_mask = W'(32'h0000_ffff);
         default:       size_mask = '1;
      endcase
   end

   // ========================================
   // shift count and shifter
   logic [5:0]   shift_cnt;
   logic [W-1:0] shift_src;
   logic [W-1:0] sh_val;
   logic         sh_c;
   logic         sh_v;
   always_comb begin
      if (op == lasu_pkg::LASU_OP_SHIFT_MEM) begin
         shift_cnt = `LASU_CNT_ONE;
      end else if (opcode[5]) begin
         shift_cnt = count_reg_val[5:0] & `LASU_CNT_MOD_MASK;
      end else if (reg_fld == 3'h0) begin
         shift_cnt = `LASU_CNT_ZERO_IS;
      end else begin
         shift_cnt = {3'h0, reg_fld};
      end
   end
   assign shift_src = (op == lasu_pkg::LASU_OP_SHIFT_MEM) ? mem_operand : data_reg_val;

   lasu_shifter #(.W(W)) u_shift (
      .operand (shift_src),
      .size    (op_size),
      .count   (shift_cnt),
      .left    (shift_direction_bit),
      .value   (sh_val),
      .carry   (sh_c),
      .ovf     (sh_v)
   );

   // ========================================
   // state
   lasu_pkg::lasu_state_t st_q, st_d;

   // next state: one instruction completes per issue cycle
   always_comb begin
      logic [W-1:0] src_b;
      logic [W-1:0] res;
      logic [W-1:0] sized;
      logic         msb;
      src_b = '0;
      res   = '0;
      sized = '0;
      msb   = 1'b0;
      st_d  = st_q;
      st_d.done    = 1'b0;
      st_d.wr_reg  = 1'b0;
      st_d.wr_mem  = 1'b0;
      st_d.illegal = 1'b0;
      if (issue) begin
         st_d.done = 1'b1;
         st_d.flags = flag_byte_in;
         if (!legal) begin
            st_d.illegal = 1'b1;
         end else if (op == lasu_pkg::LASU_OP_AND_IMMEDIATE_FLAGS) begin
            st_d.flags = flag_byte_in & ext_word0[4:0];
         end else begin
            // operand b: data register field, or effective side
            if (op == lasu_pkg::LASU_OP_AND_IMMEDIATE)
               src_b = is_dreg ? data_reg_val : mem_operand;
            else if (op == lasu_pkg::LASU_OP_AND_TO_REG)
               src_b = is_dreg ? count_reg_val : mem_operand;
            else
               src_b = mem_operand;
            case (op)
               lasu_pkg::LASU_OP_AND_IMMEDIATE:       res = src_b & imm;
               lasu_pkg::LASU_OP_AND_TO_REG: res = (ea_mode == `LASU_MODE_EXT
                                                   && ea_reg == `LASU_REG_IMM)
                                                   ? (data_reg_val & imm)
                                                   : (data_reg_val & src_b);
               lasu_pkg::LASU_OP_AND_TO_MEM: res = data_reg_val & src_b;
               default:                      res = sh_val;
            endcase
            sized = res & size_mask;
            case (op_size)
               `LASU_SZ_BYTE: msb = sized[7];
               `LASU_SZ_WORD: msb = sized[15];
               default:       msb = sized[W-1];
            endcase
            st_d.flags[`LASU_FL_N] = msb;
            st_d.flags[`LASU_FL_Z] = sized == '0;
            st_d.flags[`LASU_FL_V] = 1'b0;
            st_d.flags[`LASU_FL_C] = 1'b0;
            if (op == lasu_pkg::LASU_OP_SHIFT_REG || op == lasu_pkg::LASU_OP_SHIFT_MEM) begin
               st_d.flags[`LASU_FL_C] = sh_c;
               st_d.flags[`LASU_FL_V] = sh_v;
               if (shift_cnt != 6'h00)
                  st_d.flags[`LASU_FL_X] = sh_c;
            end
            st_d.result = (data_reg_val & ~size_mask) | sized;
            if (op == lasu_pkg::LASU_OP_AND_TO_MEM || op == lasu_pkg::LASU_OP_SHIFT_MEM
                || (op == lasu_pkg::LASU_OP_AND_IMMEDIATE && !is_dreg))
               st_d.result = sized;
            st_d.wr_mem = op == lasu_pkg::LASU_OP_AND_TO_MEM
                          || op == lasu_pkg::LASU_OP_SHIFT_MEM
                          || (op == lasu_pkg::LASU_OP_AND_IMMEDIATE && !is_dreg);
            st_d.wr_reg = !st_d.wr_mem;
            st_d.wr_idx = (op == lasu_pkg::LASU_OP_AND_TO_REG) ? reg_fld : ea_reg;
         end
      end
   end

   // register the whole state; ce freezes everything
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign result      = st_q.result;
   assign flag_byte   = st_q.flags;
   assign wr_data_reg = st_q.wr_reg;
   assign wr_mem      = st_q.wr_mem;
   assign wr_reg_idx  = st_q.wr_idx;
   assign illegal     = st_q.illegal;
   assign done        = st_q.done;

   // ========================================
   // checks
   // V and C clear after AND
   property p_and_vc;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && legal && (op == lasu_pkg::LASU_OP_AND_TO_REG
       || op == lasu_pkg::LASU_OP_AND_IMMEDIATE)) |=> (flag_byte[1:0] == 2'h0);
   endproperty
   a_and_vc: assert property (p_and_vc) else $error("and left v or c set");
   property p_and_x;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && legal && op == lasu_pkg::LASU_OP_AND_TO_MEM)
      |=> (flag_byte[4] == $past(flag_byte_in[4]));
   endproperty
   a_and_x: assert property (p_and_x) else $error("and changed x");
   property p_no_areg;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && grp == `LASU_GRP_AND && is_areg) |=> (illegal && !wr_data_reg);
   endproperty
   a_no_areg: assert property (p_no_areg) else $error("and took address reg");
   property p_mem_dreg;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && op == lasu_pkg::LASU_OP_AND_TO_MEM && is_dreg) |=> illegal;
   endproperty
   a_mem_dreg: assert property (p_mem_dreg) else $error("and to dreg ea taken");
   property p_flags_and;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && op == lasu_pkg::LASU_OP_AND_IMMEDIATE_FLAGS && legal)
      |=> (flag_byte == ($past(flag_byte_in) & $past(ext_word0[4:0])));
   endproperty
   a_flags_and: assert property (p_flags_and) else $error("flag and wrong");
   // zero count clears carry, keeps X
   property p_zero_cnt;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && legal && op == lasu_pkg::LASU_OP_SHIFT_REG && shift_cnt == 6'h00)
      |=> (!flag_byte[0] && flag_byte[4] == $past(flag_byte_in[4]));
   endproperty
   a_zero_cnt: assert property (p_zero_cnt) else $error("zero shift flags");
   // upper bits kept on byte write
   property p_upper;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && legal && op == lasu_pkg::LASU_OP_SHIFT_REG && op_size == `LASU_SZ_BYTE)
      |=> (result[W-1:8] == $past(data_reg_val[W-1:8]));
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits disturbed");
   property p_eight;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && op == lasu_pkg::LASU_OP_SHIFT_REG && !opcode[5] && reg_fld == 3'h0)
      |-> shift_cnt == `LASU_CNT_ZERO_IS;
   endproperty
   a_eight: assert property (p_eight) else $error("count zero not eight");
   property p_mem_one;
      @(posedge clk_sys) disable iff (!nrst)
      (op == lasu_pkg::LASU_OP_SHIFT_MEM)
      |-> (shift_cnt == `LASU_CNT_ONE && op_size == `LASU_SZ_WORD);
   endproperty
   a_mem_one: assert property (p_mem_one) else $error("memory shift not one word bit");
   // a refused opcode raises no write strobe
   property p_refuse_quiet;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && !legal) |=> (illegal && !wr_data_reg && !wr_mem);
   endproperty
   a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused opcode wrote");
   // nonzero count puts the last bit out in both X and C
   property p_shift_xc;
      @(posedge clk_sys) disable iff (!nrst)
      (ce && issue && op == lasu_pkg::LASU_OP_SHIFT_REG && shift_cnt != 6'h00)
      |=> (flag_byte[`LASU_FL_X] == flag_byte[`LASU_FL_C]);
   endproperty
   a_shift_xc: assert property (p_shift_xc) else $error("shift x and c differ");
endmodule // lasu_unit

// >>> dv/lasu_unit_bench.sv
// self-checking bench for the logic and arithmetic shift unit
`timescale 1ns/1ps
`include "lasu_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lasu_unit_bench;
   // =========================================
   // stimulus and observed signals
   logic        clk_sys;
   logic        nrst;
   logic        ce;
   logic        issue;
   logic [15:0] opcode;
   logic [15:0] ext_word0;
   logic [15:0] ext_word1;
   logic [31:0] data_reg_val;
   logic [31:0] count_reg_val;
   logic [31:0] mem_operand;
   logic [4:0]  flag_byte_in;
   logic [31:0] result;
   logic [4:0]  flag_byte;
   logic        wr_data_reg;
   logic        wr_mem;
   logic [2:0]  wr_reg_idx;
   logic        illegal;
   logic        done;
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;

   lasu_unit #(.W(32)) uut (
      .clk_sys, .nrst, .ce, .issue, .opcode, .ext_word0, .ext_word1,
      .data_reg_val, .count_reg_val, .mem_operand, .flag_byte_in,
      .result, .flag_byte, .wr_data_reg, .wr_mem, .wr_reg_idx, .illegal, .done
   );

   // free-running 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // =========================================
   // helpers
   function automatic logic [31:0] szm(input logic [1:0] s);
      return (s == 2'h0) ? 32'h0000_00ff : (s == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
   endfunction

   // reference shift, one position per step so the last bit out and any sign change show
   function automatic logic [36:0] shm(input logic [31:0] v, input logic [1:0] s, input int n,
                                       input logic lft, input logic xin);
      logic [31:0] m;
      logic [31:0] r;
      int          t;
      logic        c;
      logic        ov;
      logic        sg;
      m = szm(s);
      t = (s == 2'h0) ? 7 : (s == 2'h1) ? 15 : 31;
      r = v & m;
      sg = r[t];
      c = 1'b0;
      ov = 1'b0;
      for (int i = 0; i < n; i++) begin
         c = lft ? r[t] : r[0];
         r = lft ? ((r << 1) & m) : (r >> 1);
         if (!lft) r[t] = sg;
         if (r[t] != sg) ov = 1'b1;
      end
      return {(v & ~m) | r, (n == 0) ? xin : c, r[t], r == 32'h0, ov, c};
   endfunction

   // one instruction: inputs set at a falling edge, outputs judged one cycle later
   task automatic go(input logic [15:0] op, input logic [31:0] e, input logic [31:0] dv,
                     input logic [31:0] cv, input logic [31:0] mv, input logic [4:0] fl);
      @(negedge clk_sys);
      issue = 1'b1;
      opcode = op;
      ext_word0 = e[31:16];
      ext_word1 = e[15:0];
      data_reg_val = dv;
      count_reg_val = cv;
      mem_operand = mv;
      flag_byte_in = fl;
      @(negedge clk_sys);
      issue = 1'b0;
   endtask

   // strobes as {illegal, register write, memory write}
   task automatic chk(input logic [31:0] r, input logic [31:0] m, input logic [4:0] f,
                      input logic [2:0] wri, input logic [2:0] idx);
      `CHK({illegal, wr_data_reg, wr_mem}, wri)
      `CHK(done, 1'b1)
      `CHK(flag_byte, f)
      `CHK(result & m, r & m)
      if (wr_data_reg === 1'b1) `CHK(wr_reg_idx, idx)
   endtask

   // =========================================
   // scenarios
   // three forms, three sizes
   task automatic t_and;
      logic [31:0] m;
      logic [31:0] d;
      logic [31:0] src;
      logic [31:0] r;
      logic [4:0]  fx;
      for (int s = 0; s < 3; s++) begin
         for (int k = 0; k < 2; k++) begin
            m = szm(s[1:0]);
            d = 32'h8f00_8f80;
            src = k ? ~d : 32'hf0ff_f0f0;
            r = (d & ~m) | (d & src & m);
            fx = {1'b1, |(r & m & ~(m >> 1)), (r & m) == 32'h0, 2'h0};
            go(16'hca10 | 16'(s << 6), 32'h0, d, 32'h0, src, 5'h1f);
            chk(r, 32'hffff_ffff, fx, 3'h2, 3'h5);
            // a data register source arrives on the count operand
            go(16'hca03 | 16'(s << 6), 32'h0, d, src, ~src, 5'h1f);
            chk(r, 32'hffff_ffff, fx, 3'h2, 3'h5);
            go(16'hcb10 | 16'(s << 6), 32'h0, d, 32'h0, src, 5'h1f);
            chk(d & src, m, fx, 3'h1, 3'h0);
         end
      end
   endtask

   task automatic t_modes;
      logic [15:0] ops [15];
      logic [14:0] bad;
      ops = '{16'hc089, 16'hc0bc, 16'hc0ba, 16'hc0bb, 16'hc180, 16'hc189, 16'hc1bc,
              16'hc1ba, 16'hc1b9, 16'h0289, 16'h02bc, 16'h02ba, 16'h02b8, 16'he1c0,
              16'h4e71};
      // last entry is an opcode outside this unit, which must be refused
      bad = 15'h6ef1;
      for (int i = 0; i < 15; i++) begin
         go(ops[i], 32'h1234_5678, 32'h0f0f_0f0f, 32'h0, 32'h00ff_00ff, 5'h0a);
         `CHK(illegal, bad[i])
         `CHK(wr_data_reg | wr_mem, !bad[i])
      end
   endtask

   task automatic t_and_immediate;
      logic [31:0] m;
      logic [31:0] im;
      logic [31:0] r;
      logic [4:0]  fx;
      for (int s = 0; s < 3; s++) begin
         m = szm(s[1:0]);
         im = (s == 0) ? 32'h0000_0081 : (s == 1) ? 32'h0000_9a81 : 32'h9a81_c3ff;
         r = (32'hf0f0_f0f0 & ~m) | (32'hf0f0_f0f0 & im & m);
         fx = {1'b0, |(r & m & ~(m >> 1)), (r & m) == 32'h0, 2'h0};
         go(16'h0203 | 16'(s << 6), 32'h9a81_c3ff, 32'hf0f0_f0f0, 32'h0, 32'h0, 5'h0f);
         chk(r, 32'hffff_ffff, fx, 3'h2, 3'h3);
      end
      // memory destination with a zero long result
      go(16'h0290, 32'h0f0f_0f0f, 32'h0, 32'h0, 32'hf0f0_f0f0, 5'h1f);
      chk(32'h0, 32'hffff_ffff, 5'h14, 3'h1, 3'h0);
   endtask

   task automatic t_flags;
      go(16'h023c, 32'h0015_0000, 32'h0, 32'h0, 32'h0, 5'h1f);
      chk(32'h0, 32'h0, 5'h15, 3'h0, 3'h0);
      go(16'h023c, 32'h00ea_0000, 32'h0, 32'h0, 32'h0, 5'h17);
      chk(32'h0, 32'h0, 5'h02, 3'h0, 3'h0);
      // nonzero upper immediate byte is refused, flags pass through
      go(16'h023c, 32'h0115_0000, 32'h0, 32'h0, 32'h0, 5'h0b);
      chk(32'h0, 32'h0, 5'h0b, 3'h4, 3'h0);
   endtask

   // one shift case; memory form is word sized and writes memory
   task automatic sh(input logic [15:0] op, input logic [31:0] v, input logic [31:0] cv,
                     input int n, input logic [4:0] fl);
      logic [36:0] e;
      logic        mf;
      logic [1:0]  s;
      mf = (op[7:6] == 2'h3);
      s = mf ? 2'h1 : op[7:6];
      e = shm(v, s, n, op[8], fl[4]);
      if (mf) go(op, 32'h0, 32'h0, cv, v, fl);
      else go(op, 32'h0, v, cv, 32'h0, fl);
      chk(e[36:5], mf ? 32'h0000_ffff : 32'hffff_ffff, e[4:0], mf ? 3'h1 : 3'h2, op[2:0]);
   endtask

   task automatic t_shift;
      sh(16'he302, 32'h1234_5640, 32'h0, 1, 5'h00);
      sh(16'he002, 32'h1234_5685, 32'h0, 8, 5'h00);
      sh(16'hef42, 32'haaaa_0301, 32'h0, 7, 5'h00);
      sh(16'he102, 32'h1234_56c1, 32'h0, 8, 5'h00);
      sh(16'he8a1, 32'h8000_0011, 32'h0000_0043, 3, 5'h1f);
      sh(16'he9a1, 32'h8000_0011, 32'h0000_0040, 0, 5'h1f);
      sh(16'he961, 32'h1234_8001, 32'h0000_0028, 40, 5'h00);
      sh(16'he0d0, 32'h0000_8001, 32'h0, 1, 5'h00);
      sh(16'he1d0, 32'h0000_4001, 32'h0, 1, 5'h10);
   endtask

   // back-to-back issue, then a stalled enable must freeze everything
   task automatic t_b2b;
      @(negedge clk_sys);
      issue = 1'b1;
      opcode = 16'h023c;
      flag_byte_in = 5'h1f;
      ext_word0 = 16'h0013;
      @(negedge clk_sys);
      `CHK(flag_byte, 5'h13)
      ext_word0 = 16'h0004;
      @(negedge clk_sys);
      `CHK(flag_byte, 5'h04)
      ce = 1'b0;
      ext_word0 = 16'h0001;
      repeat (2) @(negedge clk_sys);
      `CHK({done, flag_byte}, 6'h24)
      ce = 1'b1;
      issue = 1'b0;
      @(negedge clk_sys);
      `CHK(done, 1'b0)
   endtask

   // reset in mid-run clears outputs at once; an issue set one cycle after release is taken
   task automatic t_reset;
      @(negedge clk_sys);
      nrst = 1'b0;
      #1;
      `CHK({result, flag_byte, done}, 38'h0)
      @(negedge clk_sys);
      nrst = 1'b1;
      go(16'h023c, 32'h0009_0000, 32'h0, 32'h0, 32'h0, 5'h1b);
      chk(32'h0, 32'h0, 5'h09, 3'h0, 3'h0);
   endtask

   // =========================================
   // verdict and hang guard
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      issue = 1'b0;
      opcode = 16'h0;
      ext_word0 = 16'h0;
      ext_word1 = 16'h0;
      data_reg_val = 32'h0;
      count_reg_val = 32'h0;
      mem_operand = 32'h0;
      flag_byte_in = 5'h0;
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      @(negedge clk_sys);
      `CHK({result, flag_byte, done, illegal}, 39'h0)
      t_and();
      t_modes();
      t_and_immediate();
      t_flags();
      t_shift();
      t_b2b();
      t_reset();
      end_of_test();
   end
endmodule // lasu_unit_bench
